// [core/ppm_pkg.sv]
package ppm_pkg;

    // ----------------------------------------
    // bus and register map
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_DATA = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_MODE = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_EPP_DATA = 8'h18;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------
    // field layouts and reset values
    // ----------------------------------------
    localparam int CTL_STROBE = 0;
    localparam int CTL_AUTOFEED = 1;
    localparam int CTL_INIT = 2;
    localparam int CTL_SELECT = 3;
    localparam int CTL_DIR = 5;
    localparam int ST_FAULT = 3;
    localparam int ST_SELECTED = 4;
    localparam int ST_PAPER = 5;
    localparam int ST_ACK = 6;
    localparam int ST_BUSY = 7;
    localparam logic [7:0] CTRL_RST = 8'h04;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [1:0] MODE_STD = 2'h0;
    localparam logic [1:0] MODE_BIDIR = 2'h1;
    localparam logic [1:0] MODE_EPP = 2'h2;
    localparam logic [1:0] MODE_ECP = 2'h3;

    // synchronised pin vector layout
    localparam int PIN_W = 13;
    localparam int PIN_FAULT = 0;
    localparam int PIN_SEL = 1;
    localparam int PIN_PAPER = 2;
    localparam int PIN_ACK = 3;
    localparam int PIN_BUSY = 4;
    localparam int PIN_DATA = 5;

    localparam int IRQ_W = 3;
    localparam int IRQ_ACK = 0;
    localparam int IRQ_FAULT = 1;
    localparam int IRQ_PAPER = 2;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int EPP_STALL_NS = 500;
    localparam int CNT_W = 3;
    localparam int EPP_STALL_I = (EPP_STALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] EPP_STALL_CYC = CNT_W'(EPP_STALL_I);
    localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WSTALL = 4'h2,
        ST_BRESP = 4'h4,
        ST_RRESP = 4'h8
    } ppm_bus_st_t;

endpackage

// [core/ppm_port_core.sv]
// What this block does
// - select pin is inverse of control bit 3 in standard and bidirectional modes
// - initialise pin follows control bit 2 directly in standard and bidirectional modes
// - autofeed pin is inverse of control bit 1 in standard and bidirectional modes
// - strobe pin is inverse of control bit 0 in standard and bidirectional modes
// - status bit 7 reads inverted busy pin
// - status bit 6 reads acknowledge pin as is
// - status bit 5 reads paper-out pin as is
// - status bit 4 reads selected pin as is
// - status bit 3 reads fault pin as is
// - shared eight-bit two-way port data bus
// - epp mode pulls host ready low to stretch
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module ppm_port_core
    import ppm_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic PRINTER_SELECT_OUT_N,
    output logic PRINTER_INITIALISE_N,
    output logic LINE_AUTOFEED_N,
    output logic DATA_STROBE_N,
    input wire logic BUSY,
    input wire logic PERIPHERAL_ACK_N,
    input wire logic PAPER_OUT,
    input wire logic PERIPHERAL_SELECTED,
    input wire logic PERIPHERAL_FAULT_N,
    input wire logic [7:0] PORT_DATA_BUS_IN,
    output logic [7:0] PORT_DATA_BUS_OUT,
    output logic PORT_DATA_BUS_OE_N,
    output logic HOST_READY_OUT,
    output logic HOST_READY_OE_N,
    output logic IRQ
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [PIN_W-1:0] meta_q, meta_d, sync_q, sync_d;
    logic [PIN_W-1:0] prev_q, prev_d;

    always_comb
    begin
        meta_d = {PORT_DATA_BUS_IN, BUSY, PERIPHERAL_ACK_N, PAPER_OUT,
                  PERIPHERAL_SELECTED, PERIPHERAL_FAULT_N};
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // ----------------------------------------
    // register bus and port state
    // ----------------------------------------
    ppm_bus_st_t st_q, st_d;
    logic aw_got_q, aw_got_d, w_got_q, w_got_d, strb_q, strb_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d, araddr_q, araddr_d;
    logic [7:0] wdata_q, wdata_d, data_q, data_d, ctrl_q, ctrl_d;
    logic [1:0] mode_q, mode_d, bresp_q, bresp_d, rresp_q, rresp_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic pull_q, pull_d, rd_pend_q, rd_pend_d;
    logic [31:0] rdata_q, rdata_d;
    logic [IRQ_W-1:0] irq_q, irq_d, mask_q, mask_d, ev, clr;
    logic wr_fire, rd_fire, drive, map_pins, epp;
    logic [7:0] status_byte, port_byte;

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        addr_ok = (a == OFF_DATA) || (a == OFF_STATUS) || (a == OFF_CONTROL)
               || (a == OFF_MODE) || (a == OFF_IRQ_STATUS)
               || (a == OFF_IRQ_MASK) || (a == OFF_EPP_DATA);
    endfunction

    function automatic logic stall_hit(input logic [ADDR_W-1:0] a, input logic [1:0] m);
        stall_hit = (m == MODE_EPP) && (a == OFF_EPP_DATA);
    endfunction

    always_comb
    begin
        map_pins = (mode_q == MODE_STD) || (mode_q == MODE_BIDIR);
        epp = (mode_q == MODE_EPP);
        drive = (mode_q == MODE_STD) || !ctrl_q[CTL_DIR];
        port_byte = drive ? data_q : sync_q[PIN_DATA +: 8];
        status_byte = 8'h00;
        status_byte[ST_BUSY] = ~sync_q[PIN_BUSY];
        status_byte[ST_ACK] = sync_q[PIN_ACK];
        status_byte[ST_PAPER] = sync_q[PIN_PAPER];
        status_byte[ST_SELECTED] = sync_q[PIN_SEL];
        status_byte[ST_FAULT] = sync_q[PIN_FAULT];
        ev = '0;
        ev[IRQ_ACK] = prev_q[PIN_ACK] & ~sync_q[PIN_ACK];
        ev[IRQ_FAULT] = prev_q[PIN_FAULT] & ~sync_q[PIN_FAULT];
        ev[IRQ_PAPER] = ~prev_q[PIN_PAPER] & sync_q[PIN_PAPER];
        clr = '0;
        st_d = st_q;
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        strb_d = strb_q;
        awaddr_d = awaddr_q;
        araddr_d = araddr_q;
        wdata_d = wdata_q;
        data_d = data_q;
        ctrl_d = ctrl_q;
        mode_d = mode_q;
        bresp_d = bresp_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        cnt_d = cnt_q;
        pull_d = pull_q;
        rd_pend_d = rd_pend_q;
        mask_d = mask_q;
        S_AXI_AWREADY = !aw_got_q;
        S_AXI_WREADY = !w_got_q;
        S_AXI_ARREADY = (st_q == ST_IDLE) && !(aw_got_q && w_got_q);
        if (S_AXI_AWVALID && S_AXI_AWREADY)
        begin
            aw_got_d = 1'b1;
            awaddr_d = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY)
        begin
            w_got_d = 1'b1;
            wdata_d = S_AXI_WDATA[7:0];
            strb_d = S_AXI_WSTRB[0];
        end
        wr_fire = 1'b0;
        rd_fire = 1'b0;
        unique case (st_q)
            ST_IDLE:
            begin
                if (aw_got_q && w_got_q)
                begin
                    st_d = ST_WSTALL;
                    rd_pend_d = 1'b0;
                    cnt_d = stall_hit(awaddr_q, mode_q) ? EPP_STALL_CYC : CNT_ONE;
                    pull_d = stall_hit(awaddr_q, mode_q);
                end
                else if (S_AXI_ARVALID)
                begin
                    st_d = ST_WSTALL;
                    rd_pend_d = 1'b1;
                    araddr_d = S_AXI_ARADDR;
                    cnt_d = stall_hit(S_AXI_ARADDR, mode_q) ? EPP_STALL_CYC : CNT_ONE;
                    pull_d = stall_hit(S_AXI_ARADDR, mode_q);
                end
            end
            ST_WSTALL:
            begin
                cnt_d = cnt_q - CNT_ONE;
                if (cnt_q == CNT_ONE)
                begin
                    pull_d = 1'b0;
                    wr_fire = !rd_pend_q;
                    rd_fire = rd_pend_q;
                    st_d = rd_pend_q ? ST_RRESP : ST_BRESP;
                end
            end
            ST_BRESP:
            begin
                if (S_AXI_BREADY)
                begin
                    st_d = ST_IDLE;
                    aw_got_d = 1'b0;
                    w_got_d = 1'b0;
                end
            end
            ST_RRESP:
            begin
                if (S_AXI_RREADY)
                begin
                    st_d = ST_IDLE;
                end
            end
        endcase
        if (wr_fire)
        begin
            bresp_d = addr_ok(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            if (strb_q)
            begin
                unique case (awaddr_q)
                    OFF_DATA, OFF_EPP_DATA: data_d = wdata_q;
                    OFF_CONTROL: ctrl_d = wdata_q;
                    OFF_MODE: mode_d = wdata_q[1:0];
                    OFF_IRQ_STATUS: clr = wdata_q[IRQ_W-1:0];
                    OFF_IRQ_MASK: mask_d = wdata_q[IRQ_W-1:0];
                    default: clr = '0;
                endcase
            end
        end
        if (rd_fire)
        begin
            rresp_d = addr_ok(araddr_q) ? RESP_OKAY : RESP_SLVERR;
            unique case (araddr_q)
                OFF_DATA, OFF_EPP_DATA: rdata_d = {24'h000000, port_byte};
                OFF_STATUS: rdata_d = {24'h000000, status_byte};
                OFF_CONTROL: rdata_d = {24'h000000, ctrl_q};
                OFF_MODE: rdata_d = {30'h00000000, mode_q};
                OFF_IRQ_STATUS: rdata_d = {29'h00000000, irq_q};
                OFF_IRQ_MASK: rdata_d = {29'h00000000, mask_q};
                default: rdata_d = 32'h00000000;
            endcase
        end
        // a new event beats a clear in the same cycle
        irq_d = (irq_q & ~clr) | ev;
    end

    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            st_q <= ST_IDLE;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            strb_q <= 1'b0;
            awaddr_q <= '0;
            araddr_q <= '0;
            wdata_q <= 8'h00;
            data_q <= DATA_RST;
            ctrl_q <= CTRL_RST;
            mode_q <= MODE_STD;
            bresp_q <= RESP_OKAY;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h00000000;
            cnt_q <= '0;
            pull_q <= 1'b0;
            rd_pend_q <= 1'b0;
            irq_q <= '0;
            mask_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            strb_q <= strb_d;
            awaddr_q <= awaddr_d;
            araddr_q <= araddr_d;
            wdata_q <= wdata_d;
            data_q <= data_d;
            ctrl_q <= ctrl_d;
            mode_q <= mode_d;
            bresp_q <= bresp_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            cnt_q <= cnt_d;
            pull_q <= pull_d;
            rd_pend_q <= rd_pend_d;
            irq_q <= irq_d;
            mask_q <= mask_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign S_AXI_BVALID = (st_q == ST_BRESP);
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_RVALID = (st_q == ST_RRESP);
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;
    // protocol modes park the pins idle; epp strobes during the stall
    assign PRINTER_SELECT_OUT_N = map_pins ? ~ctrl_q[CTL_SELECT] : 1'b1;
    assign PRINTER_INITIALISE_N = map_pins ? ctrl_q[CTL_INIT] : 1'b1;
    assign LINE_AUTOFEED_N = map_pins ? ~ctrl_q[CTL_AUTOFEED] : 1'b1;
    assign DATA_STROBE_N = map_pins ? ~ctrl_q[CTL_STROBE] : !(epp && pull_q);
    assign PORT_DATA_BUS_OUT = data_q;
    assign PORT_DATA_BUS_OE_N = !drive;
    assign HOST_READY_OUT = 1'b0;
    assign HOST_READY_OE_N = !pull_q;
    assign IRQ = |(irq_q & mask_q);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    logic ctl_wr, dat_wr, st_rd;
    assign ctl_wr = wr_fire && strb_q && (awaddr_q == OFF_CONTROL) && map_pins;
    assign dat_wr = wr_fire && strb_q && (awaddr_q == OFF_DATA) && (mode_q == MODE_STD);
    assign st_rd = rd_fire && (araddr_q == OFF_STATUS);

    property p_select;
        ctl_wr |=> PRINTER_SELECT_OUT_N == ~$past(wdata_q[CTL_SELECT]);
    endproperty
    a_select: assert property (p_select) else $error("select pin wrong");
    property p_init;
        ctl_wr |=> PRINTER_INITIALISE_N == $past(wdata_q[CTL_INIT]);
    endproperty
    a_init: assert property (p_init) else $error("init pin wrong");
    property p_autofeed;
        ctl_wr |=> LINE_AUTOFEED_N == ~$past(wdata_q[CTL_AUTOFEED]);
    endproperty
    a_autofeed: assert property (p_autofeed) else $error("autofeed pin wrong");
    property p_strobe;
        ctl_wr |=> DATA_STROBE_N == ~$past(wdata_q[CTL_STROBE]);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe pin wrong");
    property p_busy;
        st_rd |=> S_AXI_RVALID && S_AXI_RDATA[ST_BUSY] == ~$past(BUSY, 3);
    endproperty
    a_busy: assert property (p_busy) else $error("busy status wrong");
    property p_ack;
        st_rd |=> S_AXI_RDATA[ST_ACK] == $past(PERIPHERAL_ACK_N, 3);
    endproperty
    a_ack: assert property (p_ack) else $error("ack status wrong");
    property p_paper;
        st_rd |=> S_AXI_RDATA[ST_PAPER] == $past(PAPER_OUT, 3);
    endproperty
    a_paper: assert property (p_paper) else $error("paper status wrong");
    property p_sel;
        st_rd |=> S_AXI_RDATA[ST_SELECTED] == $past(PERIPHERAL_SELECTED, 3);
    endproperty
    a_sel: assert property (p_sel) else $error("selected status wrong");
    property p_fault;
        st_rd |=> S_AXI_RDATA[ST_FAULT] == $past(PERIPHERAL_FAULT_N, 3);
    endproperty
    a_fault: assert property (p_fault) else $error("fault status wrong");
    property p_data;
        dat_wr |=> !PORT_DATA_BUS_OE_N && PORT_DATA_BUS_OUT == $past(wdata_q);
    endproperty
    a_data: assert property (p_data) else $error("port data not driven");
    property p_ready;
        $fell(HOST_READY_OE_N) |-> (!HOST_READY_OE_N)[*5] ##1 HOST_READY_OE_N;
    endproperty
    a_ready: assert property (p_ready) else $error("ready stretch wrong");
    property p_modes;
        !map_pins |-> PRINTER_SELECT_OUT_N && PRINTER_INITIALISE_N && LINE_AUTOFEED_N;
    endproperty
    a_modes: assert property (p_modes) else $error("pins not parked");

    c_epp_write: cover property (wr_fire && epp && awaddr_q == OFF_EPP_DATA);
    c_status_read: cover property (st_rd ##1 S_AXI_RVALID && S_AXI_RREADY);
    c_irq: cover property ($rose(IRQ));

endmodule // ppm_port_core

`default_nettype wire

// [dv/ppm_printer_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// printer on the port cable
// ----------------------------------------
module ppm_printer_model (
    input wire logic CLOCK,
    input wire logic [4:0] status_cmd,
    input wire logic drive_en,
    input wire logic [7:0] drive_byte,
    input wire logic [7:0] dev_out,
    input wire logic dev_oe_n,
    input wire logic ready_out,
    input wire logic ready_oe_n,
    output logic busy,
    output logic ack_n,
    output logic paper_out,
    output logic selected,
    output logic fault_n,
    output logic [7:0] bus_level,
    output logic host_ready
);
    logic [7:0] last_q = 8'h00;
    assign busy = status_cmd[4];
    assign ack_n = status_cmd[3];
    assign paper_out = status_cmd[2];
    assign selected = status_cmd[1];
    assign fault_n = status_cmd[0];
    // a released bus shows the inverse of its last level
    assign bus_level = !dev_oe_n ? dev_out : (drive_en ? drive_byte : ~last_q);
    assign host_ready = !ready_oe_n ? ready_out : 1'h1;
    // remember only driven levels so a floating bus holds steady
    always @(posedge CLOCK) if (!dev_oe_n || drive_en) last_q <= bus_level;
endmodule // ppm_printer_model
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ppm_pkg::*;
;
    logic clock = 1'h0, sys_rst = 1'h1, drv_en = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, drv_byte = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [4:0] pst = 5'h0B;
    logic awready, wready, bvalid, arready, rvalid, irq, busy, ack_n, paper, selected;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic sel_n, init_n, afd_n, stb_n, fault_n, oe_n, rdy_out, rdy_oe_n, host_ready;
    logic [7:0] bus_in, bus_out;
    int errors = 0, tests_run = 0, stall_n = 0, stb_low_n = 0;

    always #50 clock = ~clock;
    always @(posedge clock)
    begin
        if (host_ready === 1'h0) stall_n <= stall_n + 1;
        if (stb_n === 1'h0) stb_low_n <= stb_low_n + 1;
    end

    ppm_port_core u_dut (.CLOCK(clock), .SYS_RST(sys_rst), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .PRINTER_SELECT_OUT_N(sel_n), .PRINTER_INITIALISE_N(init_n),
        .LINE_AUTOFEED_N(afd_n), .DATA_STROBE_N(stb_n), .BUSY(busy),
        .PERIPHERAL_ACK_N(ack_n), .PAPER_OUT(paper), .PERIPHERAL_SELECTED(selected),
        .PERIPHERAL_FAULT_N(fault_n), .PORT_DATA_BUS_IN(bus_in), .PORT_DATA_BUS_OUT(bus_out),
        .PORT_DATA_BUS_OE_N(oe_n), .HOST_READY_OUT(rdy_out), .HOST_READY_OE_N(rdy_oe_n),
        .IRQ(irq));
    ppm_printer_model u_prn (.CLOCK(clock), .status_cmd(pst), .drive_en(drv_en),
        .drive_byte(drv_byte), .dev_out(bus_out), .dev_oe_n(oe_n), .ready_out(rdy_out),
        .ready_oe_n(rdy_oe_n), .busy(busy), .ack_n(ack_n), .paper_out(paper),
        .selected(selected), .fault_n(fault_n), .bus_level(bus_in), .host_ready(host_ready));

    // ----------------------------------------
    // reporting
    // ----------------------------------------
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic give_up();
        errors++;
        $display("unexpected at %0t: wait ran out", $time);
        complete_run();
    endtask

    task automatic check(input bit ok, input string msg);
        tests_run++;
        if (!ok)
        begin
            errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    // ----------------------------------------
    // register bus master
    // ----------------------------------------
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw_done;
        bit w_done;
        bit aw_hit;
        bit w_hit;
        int n;
        aw_done = 0;
        w_done = 0;
        n = 0;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        // ready is looked at where it has settled, mid cycle, and acted on at the next edge
        while (!(aw_done && w_done))
        begin
            @(negedge clock);
            if (++n > 100) give_up();
            aw_hit = !aw_done && (awready === 1'h1);
            w_hit = !w_done && (wready === 1'h1);
            @(posedge clock);
            if (aw_hit) awvalid <= 1'h0;
            if (w_hit) wvalid <= 1'h0;
            aw_done |= aw_hit;
            w_done |= w_hit;
        end
        do
        begin
            @(negedge clock);
            if (++n > 100) give_up();
        end
        while (bvalid !== 1'h1);
        r = bresp;
        @(posedge clock);
        bready <= 1'h0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(negedge clock);
            if (++n > 100) give_up();
        end
        while (arready !== 1'h1);
        @(posedge clock);
        arvalid <= 1'h0;
        do
        begin
            @(negedge clock);
            if (++n > 100) give_up();
        end
        while (rvalid !== 1'h1);
        d = rdata;
        r = rresp;
        @(posedge clock);
        rready <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        axi_write(a, {24'h0, d}, r);
        check(r === RESP_OKAY, "write response");
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string msg);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check(r === RESP_OKAY && d === e, msg);
    endtask

    function automatic logic [31:0] exp_status(input logic [4:0] p);
        return {24'h0, ~p[4], p[3], p[2], p[1], p[0], 3'h0};
    endfunction

    function automatic bit pins_ok(input logic [7:0] c);
        return sel_n === ~c[3] && init_n === c[2] && afd_n === ~c[1] && stb_n === ~c[0];
    endfunction

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        logic [7:0] c;
        logic [31:0] d;
        logic [1:0] r;
        int s0;
        int t0;
        d = $urandom(76);
        repeat (8) @(posedge clock);
        sys_rst <= 1'h0;
        @(posedge clock);
        check(pins_ok(CTRL_RST) && oe_n === 1'h0 && irq === 1'h0, "reset pins");
        rd_chk(OFF_CONTROL, {24'h0, CTRL_RST}, "control reset");
        $display("reset test done");
        for (int i = 0; i < 12; i++)
        begin
            c = (i == 0) ? 8'h00 : (i == 1) ? 8'h0F : 8'($urandom()) & 8'h0F;
            wr(OFF_CONTROL, c);
            check(pins_ok(c), "control pins");
            rd_chk(OFF_CONTROL, {24'h0, c}, "control readback");
        end
        $display("control test done");
        for (int i = 0; i < 12; i++)
        begin
            pst <= (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($urandom());
            repeat (4) @(posedge clock);
            rd_chk(OFF_STATUS, exp_status(pst), "status bits");
        end
        $display("status test done");
        for (int i = 0; i < 6; i++)
        begin
            c = 8'($urandom());
            wr(OFF_DATA, c);
            check(bus_out === c && oe_n === 1'h0 && bus_in === c, "data out");
        end
        wr(OFF_MODE, {6'h0, MODE_BIDIR});
        wr(OFF_CONTROL, 8'h20);
        check(oe_n === 1'h1, "bus released");
        drv_en <= 1'h1;
        for (int i = 0; i < 6; i++)
        begin
            drv_byte <= 8'($urandom());
            repeat (4) @(posedge clock);
            rd_chk(OFF_DATA, {24'h0, drv_byte}, "data in");
        end
        drv_en <= 1'h0;
        wr(OFF_CONTROL, 8'h00);
        $display("data bus test done");
        axi_read(8'h1C, d, r);
        check(r === RESP_SLVERR && d === 32'h0, "unmapped read");
        axi_write(8'h1C, 32'hFF, r);
        check(r === RESP_SLVERR, "unmapped write");
        $display("unmapped test done");
        wr(OFF_IRQ_MASK, 8'h01);
        pst <= 5'h0B;
        repeat (5) @(posedge clock);
        wr(OFF_IRQ_STATUS, 8'h07);
        check(irq === 1'h0, "irq idle");
        pst <= 5'h03;
        repeat (5) @(posedge clock);
        check(irq === 1'h1, "irq raised");
        rd_chk(OFF_IRQ_STATUS, 32'h1, "irq status");
        wr(OFF_IRQ_STATUS, 8'h01);
        check(irq === 1'h0, "irq cleared");
        pst <= 5'h02;
        repeat (5) @(posedge clock);
        check(irq === 1'h0, "irq masked");
        rd_chk(OFF_IRQ_STATUS, 32'h2, "masked status");
        $display("interrupt test done");
        wr(OFF_MODE, {6'h0, MODE_EPP});
        check(sel_n === 1'h1 && init_n === 1'h1 && afd_n === 1'h1, "epp parked");
        s0 = stall_n;
        t0 = stb_low_n;
        wr(OFF_EPP_DATA, 8'h5A);
        check(stall_n - s0 == EPP_STALL_I && stb_low_n - t0 == EPP_STALL_I, "epp write");
        s0 = stall_n;
        axi_read(OFF_EPP_DATA, d, r);
        check(stall_n - s0 == EPP_STALL_I && r === RESP_OKAY, "epp read");
        wr(OFF_MODE, {6'h0, MODE_ECP});
        check(pins_ok(8'h04) && host_ready === 1'h1, "ecp parked");
        wr(OFF_MODE, {6'h0, MODE_STD});
        s0 = stall_n;
        wr(OFF_EPP_DATA, 8'hA5);
        check(stall_n == s0, "no stall outside epp");
        $display("epp test done");
        complete_run();
    end

    initial
    begin
        repeat (50000) @(posedge clock);
        give_up();
    end
endmodule // tb_top
`default_nettype wire
